// *** dv/vpp_codec_model.sv ***
// Slave codec partner: takes bit clock and frame sync from the port,
// captures sample and control word, returns one sample per frame.
// Assumes one clk domain; bit clock edges are found by sampling it.
`timescale 1ns/1ps
module vpp_codec_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        codec_master_clock_out,
   input  wire logic        frame_sync,
   input  wire logic        serial_sample_out,
   input  wire logic [15:0] tx_sample,
   output logic             serial_sample_in,
   output logic [31:0]      rx_word,
   output logic             rx_valid
);
   logic       mclk_q;  // Bit clock one cycle late
   logic [5:0] idx_r;   // Bit index in frame
   logic       drv_r;   // Sample bits being driven
   wire        fall = mclk_q & ~codec_master_clock_out;
   // Capture on falling bit clock, MSB first; drive next bit there too
   always @(posedge clk) begin
      mclk_q   <= codec_master_clock_out;
      rx_valid <= 1'b0;
      // Released line: the pull-down on the codec output takes it low
      if (!drv_r) serial_sample_in <= 1'b0;
      if (rst) begin
         idx_r            <= 6'h20;
         drv_r            <= 1'b0;
         serial_sample_in <= 1'b0;
      end else if (fall && frame_sync) begin
         idx_r            <= 6'h00;
         drv_r            <= 1'b1;
         serial_sample_in <= tx_sample[15];
      end else if (fall && idx_r < 6'h20) begin
         rx_word[5'h1f - idx_r[4:0]] <= serial_sample_out;
         idx_r    <= idx_r + 6'h01;
         rx_valid <= (idx_r == 6'h1f);
         // Sample occupies bits 0 to 15 only
         if (idx_r < 6'h0f) serial_sample_in <= tx_sample[4'he - idx_r[3:0]];
         else drv_r <= 1'b0;
      end
   end
endmodule

// *** dv/vpp_port_tb.sv ***
// Self-checking bench for the voice PCM port with a codec model.
// Assumes 100 MHz clk; tone shortened to two frames.
`timescale 1ns/1ps
module vpp_port_tb;
   import vpp_pkg::*;
   logic        clk, rst, mem_wr_en, route_wr_en, dial_valid, serial_sample_in;
   logic        codec_master_clock_out, frame_sync, serial_sample_out;
   logic        line_tx_valid, ctrl_space, dtmf_active, rx_valid;
   logic [15:0] mem_addr, mem_wdata, route_wdata, line_rx_sample, line_tx_sample;
   logic [15:0] tx_sample;
   logic [3:0]  dial_digit, dtmf_digit, tone, prev_d;
   logic [31:0] rx_word, seed, r;
   logic        seen_edge, seen_fs, prev_a, mclk_prev, fs_prev;
   int          fail_count, cmp_count, run_len, bit_rises, frame_len;
   logic [31:0] exp_frame[$];               // Notes for codec frames
   logic [15:0] exp_line[$];                // Notes for line samples
   logic [4:0]  exp_tone[$];                // Notes for tone flag changes
   logic [15:0] ctl[4] = '{16'h011c, 16'h0545, 16'h065d, 16'h075c};
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   vpp_port #(.DIAL_FRAMES_P(2)) i_vpp_port (
      .clk(clk), .rst(rst), .mem_wr_en(mem_wr_en), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .route_wr_en(route_wr_en), .route_wdata(route_wdata),
      .dial_valid(dial_valid), .dial_digit(dial_digit),
      .line_rx_sample(line_rx_sample), .serial_sample_in(serial_sample_in),
      .codec_master_clock_out(codec_master_clock_out), .frame_sync(frame_sync),
      .serial_sample_out(serial_sample_out), .line_tx_sample(line_tx_sample),
      .line_tx_valid(line_tx_valid), .ctrl_space(ctrl_space),
      .dtmf_active(dtmf_active), .dtmf_digit(dtmf_digit));
   vpp_codec_model i_vpp_codec_model (
      .clk(clk), .rst(rst), .codec_master_clock_out(codec_master_clock_out),
      .frame_sync(frame_sync), .serial_sample_out(serial_sample_out),
      .tx_sample(tx_sample), .serial_sample_in(serial_sample_in),
      .rx_word(rx_word), .rx_valid(rx_valid));
   // Xorshift source for samples
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Verdict and end of run
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (!ok) begin
         fail_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Word compare and count-range compare
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      note(got === exp, got, exp);
   endtask
   task automatic cmp_span(input int got, input int lo, input int hi);
      note(got >= lo && got <= hi, got, lo);
   endtask
   // Firmware write; strobe stays up for back-to-back writes
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      mem_wr_en = 1'b1;
      mem_addr  = a;
      mem_wdata = d;
   endtask
   // Clock and frame sync must stay low for a while
   task automatic idle_check();
      logic bad;
      bad = 1'b0;
      repeat (300) begin
         @(negedge clk);
         if (codec_master_clock_out !== 1'b0 || frame_sync !== 1'b0) bad = 1'b1;
      end
      cmp_word({31'h0, bad}, 32'h0);
   endtask
   // Bounded wait for the codec to finish a frame's words
   task automatic wait_frame();
      int n;
      n = 0;
      while (rx_valid !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) begin
         fail_count++;
         test_done();
      end
      @(negedge clk);
   endtask
   // Output watcher: pairs each result with the oldest note
   always @(posedge clk) begin
      if (rst === 1'b0) begin
         if (rx_valid === 1'b1) begin
            if (exp_frame.size() == 0) note(1'b0, rx_word, 32'h0);
            else cmp_word(rx_word, exp_frame.pop_front());
         end
         if (line_tx_valid === 1'b1) begin
            if (exp_line.size() == 0) note(1'b0, {16'h0, line_tx_sample}, 32'h0);
            else cmp_word({16'h0, line_tx_sample}, {16'h0, exp_line.pop_front()});
         end
         if (dtmf_active !== prev_a || (dtmf_active === 1'b1 && dtmf_digit !== prev_d)) begin
            if (exp_tone.size() == 0) note(1'b0, {27'h0, dtmf_active, dtmf_digit}, 32'h0);
            else cmp_word({27'h0, dtmf_active, dtmf_active ? dtmf_digit : 4'h0},
                          {27'h0, exp_tone.pop_front()});
         end
         // Half period and frame timing of the codec clock
         run_len   <= run_len + 1;
         frame_len <= frame_len + 1;
         if (codec_master_clock_out !== mclk_prev) begin
            if (seen_edge) cmp_span(run_len, 24, 25);
            seen_edge <= 1'b1;
            run_len   <= 1;
            if (codec_master_clock_out === 1'b1) bit_rises <= bit_rises + 1;
         end
         if (frame_sync === 1'b1 && fs_prev !== 1'b1) begin
            if (seen_fs) cmp_span(frame_len, 12499, 12501);
            if (seen_fs) cmp_span(bit_rises, 256, 256);
            seen_fs   <= 1'b1;
            frame_len <= 1;
            bit_rises <= 1;
         end
      end else begin
         seen_edge <= 1'b0;
         seen_fs   <= 1'b0;
      end
      mclk_prev <= codec_master_clock_out;
      fs_prev   <= frame_sync;
      prev_a    <= dtmf_active;
      prev_d    <= dtmf_digit;
   end
   // Main sequence
   initial begin
      seed = 32'he56303bf;
      {rst, mem_wr_en, route_wr_en, dial_valid} = 4'h8;
      {mem_addr, mem_wdata, route_wdata, line_rx_sample, tx_sample} = '0;
      dial_digit = 4'h0;
      fail_count = 0;
      cmp_count  = 0;
      // Short reset suffices for this port; the 5 ms hold is a board matter
      repeat (12) @(negedge clk);
      rst = 1'b0;
      cmp_word({27'h0, ctrl_space, dtmf_active, line_tx_valid, frame_sync,
                codec_master_clock_out}, 32'h10);
      wr(EN_ADDR, 16'h7784);
      @(negedge clk) mem_wr_en = 1'b0;
      idle_check();
      @(negedge clk) {route_wr_en, route_wdata} = {1'b1, ROUTE_LINEAR};
      @(negedge clk) route_wr_en = 1'b0;
      // Enable set by read-modify-write of the old word
      wr(EN_ADDR, 16'h7784 | 16'h0001);
      for (int i = 0; i < 4; i++) wr(CTRL_ADDR, ctl[i]);
      wr(CTRL_ADDR, 16'h08aa);
      cmp_word({31'h0, ctrl_space}, 32'h0);
      @(negedge clk) mem_wr_en = 1'b0;
      // One frame per pass; tone frames carry no line sample
      for (int f = 0; f < 7; f++) begin
         if (f == 2 || f == 4) begin
            tone = (f == 2) ? 4'h0 : 4'hf;
            exp_tone.push_back({1'b1, tone});
            exp_tone.push_back(5'h00);
            @(negedge clk) {dial_valid, dial_digit} = {1'b1, tone};
            @(negedge clk) dial_digit = 4'h5;
            @(negedge clk) dial_valid = 1'b0;
         end
         // Last frame with routing cleared: no sample passes either way
         if (f == 6) begin
            @(negedge clk) {route_wr_en, route_wdata} = {1'b1, ROUTE_RST};
            @(negedge clk) route_wr_en = 1'b0;
         end
         r = rnd();
         line_rx_sample = r[15:0];
         tx_sample      = r[31:16];
         exp_frame.push_back({(f < 6) ? line_rx_sample : 16'h0000,
                              (f < 4) ? ctl[f] : CTRL_IDLE});
         if (f != 2 && f != 4 && f != 6) exp_line.push_back(tx_sample);
         // Next command only after the previous one completed
         wait_frame();
      end
      // Queue drained by the control frames
      cmp_word({31'h0, ctrl_space}, 32'h1);
      @(negedge clk) rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      cmp_word({30'h0, ctrl_space, dtmf_active}, 32'h2);
      idle_check();
      cmp_word(exp_frame.size() + exp_line.size() + exp_tone.size(), 32'h0);
      test_done();
   end
endmodule

// *** hdl/vpp_pkg.sv ***
// Constants shared by the voice PCM port and its bit clock generator.
// Assumes a 100 MHz system clock and a codec fed from this port's clock.
package vpp_pkg;
   // Clock plan, in kHz as the link is specified
   localparam int unsigned CLK_KHZ        = 100000;  // System clock
   localparam int unsigned MCLK_KHZ       = 2048;    // Codec master clock
   localparam int unsigned FS_KHZ         = 8;       // Frame rate
   localparam int unsigned BITS_PER_FRAME = MCLK_KHZ / FS_KHZ;  // 256
   // Toggle ticks run at twice the master clock rate
   localparam int unsigned TICK_INC       = 2 * MCLK_KHZ;
   localparam int unsigned ACC_W          = 17;
   // Frame layout
   localparam int unsigned SAMPLE_W       = 16;
   localparam int unsigned FRAME_WORD_W   = 2 * SAMPLE_W;   // Sample then control
   localparam logic [7:0]  LAST_BIT       = 8'(BITS_PER_FRAME - 1);
   localparam logic [7:0]  IDLE_BIT       = 8'(BITS_PER_FRAME - 2);
   localparam logic [7:0]  LAST_RX_BIT    = 8'(SAMPLE_W - 1);
   // Data memory locations and their reset values
   localparam logic [15:0] EN_ADDR        = 16'h0059;
   localparam logic [15:0] CTRL_ADDR      = 16'h004b;
   localparam int unsigned EN_BIT         = 0;
   localparam logic [15:0] EN_RST         = 16'h0000;
   localparam logic [15:0] ROUTE_LINEAR   = 16'h0011;
   localparam logic [15:0] ROUTE_RST      = 16'h0000;
   localparam logic [15:0] CTRL_IDLE      = 16'h0000;  // Sent when queue is empty
   // Control queue and tone timing
   localparam int unsigned CTRL_DEPTH     = 4;
   localparam int unsigned DIAL_MS        = 100;
   localparam int unsigned DIAL_FRAMES    = DIAL_MS * FS_KHZ;
   // Voice or tone mode
   typedef enum logic {
      VPP_VOICE = 1'b0,
      VPP_TONE  = 1'b1
   } vpp_mode_t;
endpackage

// *** hdl/vpp_port.sv ***
// Voice PCM port: drives a slave codec's master clock and frame sync,
// shifts one sample each way per frame plus a queued control word.
// Assumes the firmware write port and line samples are synchronous to clk.
// Functional notes
// - Drive 2048 kHz codec clock while active
// - Emit frame sync pulse at 8 kHz
// - Exactly 256 bit clocks per frame
// - One 16-bit sample each way per frame
// - Port runs only when enable bit set
// - Routing 0x0011 passes linear samples both ways
// - Control location writes go to codec; a write into a full queue is dropped
// - Control word: register high byte, value low
// - Dial digit plays tone, then voice resumes
// - Reset restores all settings to defaults
`timescale 1ns/1ps
module vpp_port
   import vpp_pkg::*;
#(
   parameter int unsigned CTRL_DEPTH_P  = vpp_pkg::CTRL_DEPTH,
   parameter int unsigned DIAL_FRAMES_P = vpp_pkg::DIAL_FRAMES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        mem_wr_en,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   input  wire logic        route_wr_en,
   input  wire logic [15:0] route_wdata,
   input  wire logic        dial_valid,
   input  wire logic [3:0]  dial_digit,
   input  wire logic [15:0] line_rx_sample,
   input  wire logic        serial_sample_in,
   output logic             codec_master_clock_out,
   output logic             frame_sync,
   output logic             serial_sample_out,
   output logic [15:0]      line_tx_sample,
   output logic             line_tx_valid,
   output logic             ctrl_space,
   output logic             dtmf_active,
   output logic [3:0]       dtmf_digit
);
   import vpp_pkg::*;

   localparam int unsigned PTR_W = $clog2(CTRL_DEPTH_P);
   localparam int unsigned CNT_W = PTR_W + 1;
   localparam int unsigned DF_W  = $clog2(DIAL_FRAMES_P + 1);

   // Configuration state
   logic [15:0]             cfg_r, cfg_nxt;          // Enable location
   logic [15:0]             route_r, route_nxt;      // Voice routing register
   // Link state
   logic                    mclk_r, mclk_nxt;        // Master and bit clock
   logic                    fs_r, fs_nxt;            // Frame sync
   logic                    sout_r, sout_nxt;        // Serial out bit
   logic [7:0]              bit_cnt_r, bit_cnt_nxt;  // Bit index in frame
   logic [FRAME_WORD_W-1:0] tx_sh_r, tx_sh_nxt;      // Outgoing frame word
   logic [SAMPLE_W-1:0]     rx_sh_r, rx_sh_nxt;      // Incoming sample
   logic [SAMPLE_W-1:0]     ltx_r, ltx_nxt;          // Sample toward line
   logic                    ltx_v_r, ltx_v_nxt;      // Its valid pulse
   // Control queue
   logic [15:0]             q_r [CTRL_DEPTH_P];      // Queue storage
   logic [15:0]             q_nxt [CTRL_DEPTH_P];
   logic [PTR_W-1:0]        wp_r, wp_nxt;            // Write index
   logic [PTR_W-1:0]        rp_r, rp_nxt;            // Read index
   logic [CNT_W-1:0]        cnt_r, cnt_nxt;          // Fill level
   logic                    space_r, space_nxt;      // Room for a word
   // Tone state
   vpp_mode_t               mode_r, mode_nxt;        // Voice or tone
   logic [DF_W-1:0]         df_r, df_nxt;            // Tone frames left
   logic                    tone_r, tone_nxt;        // Tone flag out
   logic [3:0]              dig_r, dig_nxt;          // Tone digit
   // Working terms
   logic                    tick;                    // Half-period tick
   logic                    en;                      // Port enabled
   logic                    linear;                  // Linear routing chosen
   logic                    push, pop;               // Queue moves
   logic [FRAME_WORD_W-1:0] word;                    // Frame word to load

   // Half-period ticks for the 2048 kHz clock, only while enabled
   vpp_tick_gen #(
      .ACC_W   (ACC_W),
      .INC     (TICK_INC),
      .MODULUS (CLK_KHZ)
   ) u_tick (
      .clk  (clk),
      .rst  (rst),
      .run  (en),
      .tick (tick)
   );

   // Next state for configuration, queue, link and tone
   always_comb begin
      cfg_nxt     = cfg_r;
      route_nxt   = route_r;
      mclk_nxt    = mclk_r;
      fs_nxt      = fs_r;
      sout_nxt    = sout_r;
      bit_cnt_nxt = bit_cnt_r;
      tx_sh_nxt   = tx_sh_r;
      rx_sh_nxt   = rx_sh_r;
      ltx_nxt     = ltx_r;
      ltx_v_nxt   = 1'b0;
      q_nxt       = q_r;
      wp_nxt      = wp_r;
      rp_nxt      = rp_r;
      cnt_nxt     = cnt_r;
      mode_nxt    = mode_r;
      df_nxt      = df_r;
      dig_nxt     = dig_r;
      pop         = 1'b0;
      word        = '0;
      en          = cfg_r[EN_BIT];
      linear      = (route_r == ROUTE_LINEAR);
      // Firmware writes to the enable location keep every bit
      if (mem_wr_en && mem_addr == EN_ADDR) begin
         cfg_nxt = mem_wdata;
      end
      if (route_wr_en) begin
         route_nxt = route_wdata;
      end
      // Control writes are queued; a write into a full queue is dropped
      push = mem_wr_en && (mem_addr == CTRL_ADDR) && (cnt_r < CNT_W'(CTRL_DEPTH_P));
      if (push) begin
         q_nxt[wp_r] = mem_wdata;
         wp_nxt      = wp_r + 1'b1;
      end
      // Dial request starts a tone when in voice mode
      if (mode_r == VPP_VOICE && dial_valid && en) begin
         mode_nxt = VPP_TONE;
         dig_nxt  = dial_digit;
         df_nxt   = DF_W'(DIAL_FRAMES_P);
      end
      if (!en) begin
         // Idle link; first rise after enable lands on the sync bit
         mclk_nxt    = 1'b0;
         fs_nxt      = 1'b0;
         sout_nxt    = 1'b0;
         bit_cnt_nxt = IDLE_BIT;
      end else if (tick) begin
         mclk_nxt = ~mclk_r;
         if (!mclk_r) begin
            // Rising edge: advance bit index and drive out
            bit_cnt_nxt = bit_cnt_r + 8'h01;
            fs_nxt      = (bit_cnt_nxt == LAST_BIT);
            if (bit_cnt_nxt == 8'h00) begin
               // Frame start: sample then one control word
               word[FRAME_WORD_W-1:SAMPLE_W] = linear ? line_rx_sample : '0;
               word[SAMPLE_W-1:0]            = CTRL_IDLE;
               if (cnt_r != '0) begin
                  word[SAMPLE_W-1:0] = q_r[rp_r];
                  pop                = 1'b1;
                  rp_nxt             = rp_r + 1'b1;
               end
               sout_nxt  = word[FRAME_WORD_W-1];
               tx_sh_nxt = {word[FRAME_WORD_W-2:0], 1'b0};
               // Tone counts down at each frame start; voice resumes at the frame start where the count runs out
               if (mode_r == VPP_TONE) begin
                  df_nxt = df_r - 1'b1;
                  if (df_r <= DF_W'(1)) begin
                     mode_nxt = VPP_VOICE;
                  end
               end
            end else begin
               sout_nxt  = tx_sh_r[FRAME_WORD_W-1];
               tx_sh_nxt = {tx_sh_r[FRAME_WORD_W-2:0], 1'b0};
            end
         end else if (bit_cnt_r <= LAST_RX_BIT) begin
            // Falling edge: take the codec's sample MSB first
            rx_sh_nxt = {rx_sh_r[SAMPLE_W-2:0], serial_sample_in};
            if (bit_cnt_r == LAST_RX_BIT) begin
               ltx_nxt   = {rx_sh_r[SAMPLE_W-2:0], serial_sample_in};
               ltx_v_nxt = linear && (mode_r == VPP_VOICE);
            end
         end
      end
      // Queue fill level follows push and pop
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      space_nxt = (cnt_nxt < CNT_W'(CTRL_DEPTH_P));
      tone_nxt  = (mode_nxt == VPP_TONE);
   end

   // Register everything; reset brings back factory settings
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r     <= EN_RST;
         route_r   <= ROUTE_RST;
         mclk_r    <= 1'b0;
         fs_r      <= 1'b0;
         sout_r    <= 1'b0;
         bit_cnt_r <= IDLE_BIT;
         tx_sh_r   <= '0;
         rx_sh_r   <= '0;
         ltx_r     <= '0;
         ltx_v_r   <= 1'b0;
         for (int i = 0; i < CTRL_DEPTH_P; i++) begin
            q_r[i] <= '0;
         end
         wp_r      <= '0;
         rp_r      <= '0;
         cnt_r     <= '0;
         space_r   <= 1'b1;
         mode_r    <= VPP_VOICE;
         df_r      <= '0;
         tone_r    <= 1'b0;
         dig_r     <= 4'h0;
      end else begin
         cfg_r     <= cfg_nxt;
         route_r   <= route_nxt;
         mclk_r    <= mclk_nxt;
         fs_r      <= fs_nxt;
         sout_r    <= sout_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         tx_sh_r   <= tx_sh_nxt;
         rx_sh_r   <= rx_sh_nxt;
         ltx_r     <= ltx_nxt;
         ltx_v_r   <= ltx_v_nxt;
         q_r       <= q_nxt;
         wp_r      <= wp_nxt;
         rp_r      <= rp_nxt;
         cnt_r     <= cnt_nxt;
         space_r   <= space_nxt;
         mode_r    <= mode_nxt;
         df_r      <= df_nxt;
         tone_r    <= tone_nxt;
         dig_r     <= dig_nxt;
      end
   end

   // Outputs straight from flops
   assign codec_master_clock_out = mclk_r;
   assign frame_sync             = fs_r;
   assign serial_sample_out      = sout_r;
   assign line_tx_sample         = ltx_r;
   assign line_tx_valid          = ltx_v_r;
   assign ctrl_space             = space_r;
   assign dtmf_active            = tone_r;
   assign dtmf_digit             = dig_r;

   // Helper: bit clock rises and line samples between frame syncs
   logic [8:0] rises_r;   // Rises since last sync rise
   logic [1:0] vals_r;    // Line samples since last sync rise
   logic       seen_r;    // A full frame is being counted
   always_ff @(posedge clk) begin
      if (rst || !en) begin
         rises_r <= '0;
         vals_r  <= '0;
         seen_r  <= 1'b0;
      end else begin
         if ($rose(frame_sync)) begin
            rises_r <= 9'h001;
            vals_r  <= 2'(line_tx_valid);
            seen_r  <= 1'b1;
         end else begin
            if ($rose(codec_master_clock_out)) begin
               rises_r <= rises_r + 9'h001;
            end
            if (line_tx_valid && vals_r != 2'h3) begin
               vals_r <= vals_r + 2'h1;
            end
         end
      end
   end

   clk_off_a: assert property (@(posedge clk) disable iff (rst)
      !cfg_r[EN_BIT] |=> !codec_master_clock_out) else $error("clock runs while disabled");
   fs_pos_a: assert property (@(posedge clk) disable iff (rst)
      frame_sync |-> bit_cnt_r == LAST_BIT && cfg_r[EN_BIT]) else $error("sync off slot");
   frame_len_a: assert property (@(posedge clk) disable iff (rst || !en)
      $rose(frame_sync) && seen_r |-> rises_r == 9'h100) else $error("frame not 256 bits");
   one_samp_a: assert property (@(posedge clk) disable iff (rst || !en)
      $rose(frame_sync) && seen_r |-> vals_r <= 2'h1) else $error("extra line sample");
   en_gate_a: assert property (@(posedge clk) disable iff (rst)
      !cfg_r[EN_BIT] |-> ##1 !frame_sync [*2]) else $error("sync while disabled");
   route_a: assert property (@(posedge clk) disable iff (rst)
      line_tx_valid |-> $past(route_r) == ROUTE_LINEAR) else $error("sample without routing");
   msb_first_a: assert property (@(posedge clk) disable iff (rst)
      $rose(codec_master_clock_out) && bit_cnt_r == 8'h00 && $past(linear)
      |-> serial_sample_out == $past(line_rx_sample[SAMPLE_W-1])) else $error("not MSB first");
   ctrl_order_a: assert property (@(posedge clk) disable iff (rst)
      pop |=> tx_sh_r[15:1] == $past(q_r[rp_r][14:0]) && rp_r == $past(rp_r) + 1'b1)
      else $error("control word misplaced");
   tone_a: assert property (@(posedge clk) disable iff (rst)
      mode_r == VPP_VOICE && dial_valid && en |=> dtmf_active && dtmf_digit == $past(dial_digit))
      else $error("tone not started");
   rst_def_a: assert property (@(posedge clk)
      $past(rst) |-> route_r == ROUTE_RST && cfg_r == EN_RST && !dtmf_active)
      else $error("reset left settings");
endmodule

// *** hdl/vpp_tick_gen.sv ***
// Fractional tick generator: a phase accumulator that pulses tick at
// INC/MODULUS of the clock rate. Assumes INC is below MODULUS.
`timescale 1ns/1ps
module vpp_tick_gen #(
   parameter int unsigned ACC_W   = 17,
   parameter int unsigned INC     = 4096,
   parameter int unsigned MODULUS = 100000
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   output logic      tick
);
   logic [ACC_W-1:0] acc_r;    // Phase accumulator
   logic [ACC_W-1:0] acc_nxt;  // Next phase
   logic             tick_r;   // Registered wrap pulse
   logic             tick_nxt; // Next wrap pulse
   logic [ACC_W:0]   sum;      // Phase plus step

   // Step the phase, wrap at the modulus
   always_comb begin
      sum      = {1'b0, acc_r} + (ACC_W+1)'(INC);
      acc_nxt  = acc_r;
      tick_nxt = 1'b0;
      if (!run) begin
         acc_nxt = '0;
      end else if (sum >= (ACC_W+1)'(MODULUS)) begin
         acc_nxt  = ACC_W'(sum - (ACC_W+1)'(MODULUS));
         tick_nxt = 1'b1;
      end else begin
         acc_nxt = sum[ACC_W-1:0];
      end
   end

   // Register phase and pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         acc_r  <= acc_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule
